// >>> src/touch_slider_spi_command_set.sv
`timescale 1ns/1ps
// Function
// - After reset the device enters a full calibration but raises no burst_start for its first burst
// - No link traffic is taken while calibrating; calibrate answers standard byte
// - Command 0x03 gives one drift step request; standard byte follows
// - Ten drift requests move the reference by one count toward signal
// - Drift requests are dropped entirely while touch is detected
// - With select held high, free-running bursts use fixed drift setting six
// - Command 0x04 makes the next shift return the status byte
// - Status: touch bit 7, zero bit 6, bit 1 calibration error
// - Command 10xxxxxx loads its low six bits as threshold operand
// - Threshold operand is multiplied by four before compare
// - Touch release uses hysteresis of one eighth of scaled threshold
// - Crossing threshold sets response touch bit and touch detect pin
// - Threshold operand resets to ten
// - Select rising after a command starts a new acquisition burst
// - Touched standard byte carries bit 7 set and previous position
// - Data changes on falling clock edge and is sampled on rising
module touch_slider_spi_command_set #(
    parameter int FREE_RUN_CYCLES = touch_slider_pkg::FREE_RUN_CYCLES
) (
    input  wire logic                              clk_sys,
    input  wire logic                              reset_n,
    input  wire logic                              spi_clk,
    input  wire logic                              slave_select_n,
    input  wire logic                              mosi,
    input  wire logic                              acq_valid,
    input  wire logic [touch_slider_pkg::SIG_W-1:0] acq_signal,
    input  wire logic [6:0]                        acq_position,
    output logic                                   miso,
    output logic                                   data_ready_line,
    output logic                                   touch_detect,
    output logic                                   burst_start,
    output logic [touch_slider_pkg::SIG_W-1:0]     reference_level,
    output logic [5:0]                             threshold_operand,
    output logic                                   cal_error
);
    localparam int SW = touch_slider_pkg::SIG_W;

    touch_slider_pkg::ctrl_state_e state;
    touch_slider_pkg::ctrl_state_e next_state;
    touch_slider_pkg::link_evt_s   evt;
    logic [31:0]   free_cnt;
    logic [31:0]   next_free_cnt;
    logic [3:0]    cal_cnt;
    logic [3:0]    next_cal_cnt;
    logic [3:0]    drift_cnt;
    logic [3:0]    next_drift_cnt;
    logic [3:0]    free_drift_cnt;
    logic [3:0]    next_free_drift_cnt;
    logic          free_burst;
    logic          next_free_burst;
    logic          cmd_seen;
    logic          next_cmd_seen;
    logic          cal_req;
    logic          next_cal_req;
    logic          status_pend;
    logic          next_status_pend;
    logic [6:0]    position;
    logic [6:0]    next_position;
    logic [SW-1:0] next_reference_level;
    logic [5:0]    next_threshold_operand;
    logic          next_cal_error;
    logic          next_touch_detect;
    logic          next_burst_start;
    logic [7:0]    tx_byte;
    logic [SW:0]   delta;
    logic [SW:0]   thr_on;
    logic [SW:0]   thr_off;
    logic          step_drift;

    spi_byte_shifter link (
        .clk_sys        (clk_sys),
        .reset_n        (reset_n),
        .spi_clk        (spi_clk),
        .slave_select_n (slave_select_n),
        .mosi           (mosi),
        .enable         (state == touch_slider_pkg::ST_READY),
        .tx_byte        (tx_byte),
        .miso           (miso),
        .evt            (evt)
    );

    // Status byte only on the shift after 0x04; otherwise standard byte
    always_comb begin
        if (status_pend) begin
            tx_byte = 8'h00;
            tx_byte[touch_slider_pkg::TOUCH_BIT]   = touch_detect;
            tx_byte[touch_slider_pkg::TYPE_BIT]    = touch_slider_pkg::SENSOR_WHEEL;
            tx_byte[touch_slider_pkg::CAL_ERR_BIT] = cal_error;
        end else if (touch_detect) begin
            tx_byte = {1'b1, position};
        end else begin
            tx_byte = 8'h00;
        end
    end

    // Signal above reference; thresholds in the same signed width
    always_comb begin
        delta   = {1'b0, acq_signal} - {1'b0, reference_level};
        thr_on  = (SW+1)'({threshold_operand, 2'b00});
        thr_off = thr_on - (thr_on >> touch_slider_pkg::HYST_SH);
    end

    always_comb begin
        next_state             = state;
        next_free_cnt          = free_cnt;
        next_cal_cnt           = cal_cnt;
        next_drift_cnt         = drift_cnt;
        next_free_drift_cnt    = free_drift_cnt;
        next_free_burst        = free_burst;
        next_cmd_seen          = cmd_seen;
        next_cal_req           = cal_req;
        next_status_pend       = status_pend;
        next_position          = position;
        next_reference_level   = reference_level;
        next_threshold_operand = threshold_operand;
        next_cal_error         = cal_error;
        next_touch_detect      = touch_detect;
        next_burst_start       = 1'b0;
        step_drift             = 1'b0;

        if (evt.byte_done) begin
            next_cmd_seen    = 1'b1;
            next_status_pend = (evt.rx_byte == touch_slider_pkg::CMD_STATUS);
            if (evt.rx_byte == touch_slider_pkg::CMD_CALIBRATE) begin
                next_cal_req = 1'b1;
            end else if (evt.rx_byte == touch_slider_pkg::CMD_DRIFT && !touch_detect) begin
                if (drift_cnt == touch_slider_pkg::DRIFT_CMDS - 4'h1) begin
                    next_drift_cnt = 4'h0;
                    step_drift     = 1'b1;
                end else begin
                    next_drift_cnt = drift_cnt + 4'h1;
                end
            end else if (evt.rx_byte[7:6] == touch_slider_pkg::CMD_THR_TAG) begin
                next_threshold_operand = evt.rx_byte[5:0];
            end
            // Any other code falls through as a null command
        end

        // Free-run timer restarts on every select edge so it never races the host
        if (!evt.ss_high || evt.ss_rise || state != touch_slider_pkg::ST_READY) begin
            next_free_cnt = 32'h0;
        end else begin
            next_free_cnt = free_cnt + 32'h1;
        end

        case (state)
            touch_slider_pkg::ST_READY: begin
                if (evt.ss_rise && (cmd_seen ? cal_req : 1'b0)) begin
                    next_state     = touch_slider_pkg::ST_CAL;
                    next_cal_cnt   = 4'h0;
                    next_cal_error = 1'b0;
                    next_cal_req   = 1'b0;
                    next_cmd_seen  = 1'b0;
                    next_burst_start = 1'b1;
                end else if (evt.ss_rise) begin
                    next_state       = touch_slider_pkg::ST_BURST;
                    next_free_burst  = 1'b0;
                    next_cmd_seen    = 1'b0;
                    next_burst_start = 1'b1;
                end else if (free_cnt == FREE_RUN_CYCLES - 1) begin
                    next_state       = touch_slider_pkg::ST_BURST;
                    next_free_burst  = 1'b1;
                    next_burst_start = 1'b1;
                end
            end
            touch_slider_pkg::ST_BURST: begin
                if (acq_valid) begin
                    next_state    = touch_slider_pkg::ST_READY;
                    next_position = acq_position;
                    if ($signed(delta) >= $signed(thr_on)) begin
                        next_touch_detect = 1'b1;
                    end else if ($signed(delta) < $signed(thr_off)) begin
                        next_touch_detect = 1'b0;
                    end
                    // Signal well below reference means a finger sat on it at calibration
                    if ($signed(delta) <= -$signed(thr_on)) begin
                        next_cal_error = 1'b1;
                    end
                    if (free_burst && !touch_detect) begin
                        if (free_drift_cnt == touch_slider_pkg::FREE_DRIFT - 4'h1) begin
                            next_free_drift_cnt = 4'h0;
                            step_drift          = 1'b1;
                        end else begin
                            next_free_drift_cnt = free_drift_cnt + 4'h1;
                        end
                    end
                end
            end
            touch_slider_pkg::ST_CAL: begin
                if (acq_valid) begin
                    next_reference_level = acq_signal;
                    next_touch_detect    = 1'b0;
                    if (cal_cnt == touch_slider_pkg::CAL_BURSTS - 4'h1) begin
                        next_state = touch_slider_pkg::ST_READY;
                    end else begin
                        next_cal_cnt     = cal_cnt + 4'h1;
                        next_burst_start = 1'b1;
                    end
                end
            end
            default: begin
                next_state = touch_slider_pkg::ST_READY;
            end
        endcase

        // One count toward the live signal
        if (step_drift) begin
            if (acq_signal > reference_level) begin
                next_reference_level = reference_level + SW'(1);
            end else if (acq_signal < reference_level) begin
                next_reference_level = reference_level - SW'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state             <= touch_slider_pkg::ST_CAL;
            free_cnt          <= 32'h0;
            cal_cnt           <= 4'h0;
            drift_cnt         <= 4'h0;
            free_drift_cnt    <= 4'h0;
            free_burst        <= 1'b0;
            cmd_seen          <= 1'b0;
            cal_req           <= 1'b0;
            status_pend       <= 1'b0;
            position          <= 7'h00;
            reference_level   <= '0;
            threshold_operand <= touch_slider_pkg::THR_DEFAULT;
            cal_error         <= 1'b0;
            touch_detect      <= 1'b0;
            burst_start       <= 1'b0;
            data_ready_line   <= 1'b0;
        end else begin
            state             <= next_state;
            free_cnt          <= next_free_cnt;
            cal_cnt           <= next_cal_cnt;
            drift_cnt         <= next_drift_cnt;
            free_drift_cnt    <= next_free_drift_cnt;
            free_burst        <= next_free_burst;
            cmd_seen          <= next_cmd_seen;
            cal_req           <= next_cal_req;
            status_pend       <= next_status_pend;
            position          <= next_position;
            reference_level   <= next_reference_level;
            threshold_operand <= next_threshold_operand;
            cal_error         <= next_cal_error;
            touch_detect      <= next_touch_detect;
            burst_start       <= next_burst_start;
            data_ready_line   <= (next_state == touch_slider_pkg::ST_READY);
        end
    end

    ready_busy_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        data_ready_line == (state == touch_slider_pkg::ST_READY))
        else $error("data ready does not track idle state");
    burst_on_rise_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (evt.ss_rise && state == touch_slider_pkg::ST_READY) |=> burst_start)
        else $error("select rise did not start a burst");
    thr_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (evt.byte_done && evt.rx_byte[7:6] == 2'h2) |=> threshold_operand == $past(evt.rx_byte[5:0]))
        else $error("threshold operand not loaded");
    drift_touch_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (evt.byte_done && evt.rx_byte == 8'h03 && touch_detect) |=> $stable(drift_cnt))
        else $error("drift counted while touched");
    drift_step_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ($past(state) != touch_slider_pkg::ST_CAL && reference_level != $past(reference_level))
        |-> $past(drift_cnt) == 4'h9 || $past(free_drift_cnt) == 4'h5)
        else $error("reference moved without ten drift requests");
    status_byte_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        status_pend |-> tx_byte == {touch_detect, 5'h00, cal_error, 1'b0})
        else $error("status byte layout wrong");
    status_sel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (evt.byte_done && evt.rx_byte == 8'h04) |=> status_pend)
        else $error("status not armed after 0x04");
    touch_enter_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state == touch_slider_pkg::ST_BURST && acq_valid
         && $signed(delta) >= $signed({5'h00, threshold_operand, 2'b00})) |=> touch_detect)
        else $error("touch not flagged above scaled threshold");
    std_resp_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!status_pend && touch_detect) |-> tx_byte == {1'b1, position})
        else $error("standard response lacks position");

endmodule

// >>> src/touch_slider_pkg.sv
package touch_slider_pkg;

    localparam int SIG_W = 12;

    localparam logic [7:0] CMD_NULL      = 8'h00;
    localparam logic [7:0] CMD_CALIBRATE = 8'h01;
    localparam logic [7:0] CMD_DRIFT     = 8'h03;
    localparam logic [7:0] CMD_STATUS    = 8'h04;
    localparam logic [1:0] CMD_THR_TAG   = 2'h2;

    localparam int         TOUCH_BIT     = 7;
    localparam int         TYPE_BIT      = 6;
    localparam int         CAL_ERR_BIT   = 1;
    localparam logic       SENSOR_WHEEL  = 1'h0;

    localparam logic [5:0] THR_DEFAULT   = 6'h0a;
    localparam int         THR_SCALE_SH  = 2;
    localparam int         HYST_SH       = 3;

    localparam logic [3:0] CAL_BURSTS    = 4'ha;
    localparam logic [3:0] DRIFT_CMDS    = 4'ha;
    localparam logic [3:0] FREE_DRIFT    = 4'h6;

    localparam int CLK_PERIOD_NS      = 10;
    localparam int FREE_RUN_PERIOD_NS = 58_800_000;
    localparam int FREE_RUN_CYCLES    = FREE_RUN_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_READY = 3'b001,
        ST_BURST = 3'b010,
        ST_CAL   = 3'b100
    } ctrl_state_e;

    typedef struct packed {
        logic       byte_done;
        logic       ss_rise;
        logic       ss_high;
        logic [7:0] rx_byte;
    } link_evt_s;

endpackage

// >>> src/spi_byte_shifter.sv
`timescale 1ns/1ps
module spi_byte_shifter (
    input  wire logic                          clk_sys,
    input  wire logic                          reset_n,
    input  wire logic                          spi_clk,
    input  wire logic                          slave_select_n,
    input  wire logic                          mosi,
    input  wire logic                          enable,
    input  wire logic [7:0]                    tx_byte,
    output logic                               miso,
    output touch_slider_pkg::link_evt_s        evt
);
    logic [2:0] sck_s;
    logic [2:0] ss_s;
    logic [1:0] mosi_s;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [3:0] bit_cnt;
    logic [7:0] next_rx_sh;
    logic [7:0] next_tx_sh;
    logic [3:0] next_bit_cnt;
    logic       next_miso;
    touch_slider_pkg::link_evt_s next_evt;

    // Stage 0 feeds only stage 1; edges are found between stages 1 and 2
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sck_s  <= 3'h0;
            ss_s   <= 3'h7;
            mosi_s <= 2'h0;
        end else begin
            sck_s  <= {sck_s[1:0], spi_clk};
            ss_s   <= {ss_s[1:0], slave_select_n};
            mosi_s <= {mosi_s[0], mosi};
        end
    end

    always_comb begin
        next_rx_sh        = rx_sh;
        next_tx_sh        = tx_sh;
        next_bit_cnt      = bit_cnt;
        next_miso         = miso;
        next_evt          = evt;
        next_evt.byte_done = 1'b0;
        next_evt.ss_rise  = ss_s[1] & ~ss_s[2];
        next_evt.ss_high  = ss_s[1];
        if (ss_s[2] & ~ss_s[1]) begin
            next_tx_sh   = tx_byte;
            next_miso    = tx_byte[7];
            next_bit_cnt = 4'h0;
        end else if (!ss_s[1] && enable && bit_cnt < 4'h8) begin
            if (sck_s[1] & ~sck_s[2]) begin
                next_rx_sh   = {rx_sh[6:0], mosi_s[1]};
                next_bit_cnt = bit_cnt + 4'h1;
                if (bit_cnt == 4'h7) begin
                    next_evt.byte_done = 1'b1;
                    next_evt.rx_byte   = {rx_sh[6:0], mosi_s[1]};
                end
            end else if ((sck_s[2] & ~sck_s[1]) && bit_cnt != 4'h0) begin
                next_tx_sh = {tx_sh[6:0], 1'b0};
                next_miso  = tx_sh[6];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rx_sh   <= 8'h00;
            tx_sh   <= 8'h00;
            bit_cnt <= 4'h0;
            miso    <= 1'b0;
            evt     <= '{byte_done: 1'b0, ss_rise: 1'b0, ss_high: 1'b1, rx_byte: 8'h00};
        end else begin
            rx_sh   <= next_rx_sh;
            tx_sh   <= next_tx_sh;
            bit_cnt <= next_bit_cnt;
            miso    <= next_miso;
            evt     <= next_evt;
        end
    end

    byte_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        evt.byte_done |-> $past(bit_cnt) == 4'h7)
        else $error("byte completed without eight rising clocks");

endmodule

// >>> verification/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic clk_sys,
    input  wire logic miso,
    output logic      spi_clk,
    output logic      slave_select_n,
    output logic      mosi
);
    localparam realtime HALF = 62.5;
    initial begin
        spi_clk = 1'b0;
        slave_select_n = 1'b1;
        mosi = 1'b1;
    end
    // One byte each way per frame; the clock stands low between frames
    task automatic xfer(input logic [7:0] cmd, output logic [7:0] rx);
        @(posedge clk_sys);
        #2;
        slave_select_n = 1'b0;
        mosi = cmd[7];
        for (int i = 7; i >= 0; i--) begin
            #HALF;
            spi_clk = 1'b1;
            rx[i] = miso;
            #HALF;
            spi_clk = 1'b0;
            if (i > 0) mosi = cmd[i-1];
        end
        #HALF;
        slave_select_n = 1'b1;
        // Released line shows the inverse, so a stale bit cannot pass for data
        mosi = ~mosi;
    endtask
    // Select pulse with no clocks in place of a null
    task automatic pulse();
        @(posedge clk_sys);
        #2;
        slave_select_n = 1'b0;
        #300;
        slave_select_n = 1'b1;
    endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int W = touch_slider_pkg::SIG_W;
    logic         clk_sys = 1'b0;
    logic         reset_n = 1'b0;
    logic         spi_clk, slave_select_n, mosi, miso, data_ready_line;
    logic         acq_valid = 1'b0;
    logic [W-1:0] acq_signal = 12'h400;
    logic [6:0]   acq_position = 7'h00;
    logic         touch_detect, burst_start, cal_error;
    logic [W-1:0] reference_level, exp_ref;
    logic [5:0]   threshold_operand, exp_thr;
    logic [6:0]   last_pos = 7'h00;
    logic [7:0]   rx;
    logic         exp_touch, exp_cal, was_status, kick, slow;
    int           n_mismatch = 0, n_compared = 0, n_acq = 0, acq_wait = 0, dcnt = 0;
    int           t4, base, tries;
    int           offs[6];

    always #5 clk_sys = ~clk_sys;

    spi_host_model host (.clk_sys(clk_sys), .miso(miso), .spi_clk(spi_clk),
        .slave_select_n(slave_select_n), .mosi(mosi));

    touch_slider_spi_command_set #(.FREE_RUN_CYCLES(200)) uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .spi_clk(spi_clk),
        .slave_select_n(slave_select_n), .mosi(mosi), .acq_valid(acq_valid),
        .acq_signal(acq_signal), .acq_position(acq_position), .miso(miso),
        .data_ready_line(data_ready_line), .touch_detect(touch_detect),
        .burst_start(burst_start), .reference_level(reference_level),
        .threshold_operand(threshold_operand), .cal_error(cal_error));

    // Acquisition front end: answers each burst request promptly or slowly
    always @(posedge clk_sys) begin
        acq_valid <= 1'b0;
        if (burst_start === 1'b1 || kick) begin
            acq_wait <= slow ? 40 : 2 + $urandom % 8;
        end else if (acq_wait > 0) begin
            acq_wait <= acq_wait - 1;
            if (acq_wait == 1) begin
                last_pos = 7'($urandom);
                acq_position <= last_pos;
                acq_valid <= 1'b1;
                n_acq++;
            end
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Counts: compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Waits for k finished bursts and data ready high again
    task automatic settle(input int from, input int k);
        int i;
        for (i = 0; i < 20000; i++) begin
            @(posedge clk_sys);
            #1;
            if (n_acq >= from + k && data_ready_line === 1'b1) break;
        end
        if (i == 20000) begin
            n_mismatch++;
            finish_test();
        end else begin
            check(16'(n_acq - from), 16'(k));
        end
    endtask

    task automatic check_state();
        check(16'(touch_detect), 16'(exp_touch));
        check(16'(reference_level), 16'(exp_ref));
        check(16'(threshold_operand), 16'(exp_thr));
        check(16'(cal_error), 16'(exp_cal));
    endtask

    // One command with the channel signal at reference plus off
    task automatic cmd(input logic [7:0] c, input int off, input bit bare);
        logic [7:0] exp;
        int         diff;
        @(posedge clk_sys);
        acq_signal <= exp_ref + W'(off);
        exp = was_status ? {exp_touch, 1'b0, 4'h0, exp_cal, 1'b0}
                         : (exp_touch ? {1'b1, last_pos} : 8'h00);
        base = n_acq;
        if (bare) host.pulse();
        else host.xfer(c, rx);
        if (!bare) check(16'(rx), 16'(exp));
        if (!bare && c[7:6] == touch_slider_pkg::CMD_THR_TAG) exp_thr = c[5:0];
        if (!bare && c == 8'h03 && !exp_touch) dcnt++;
        if (dcnt == 10) begin
            dcnt = 0;
            exp_ref = exp_ref + W'(acq_signal > exp_ref) - W'(acq_signal < exp_ref);
        end
        if (!bare) was_status = (c == 8'h04);
        settle(base, 1);
        diff = int'(acq_signal) - int'(exp_ref);
        t4 = int'(exp_thr) * 4;
        if (diff >= t4) exp_touch = 1'b1;
        else if (diff < t4 - t4 / 8) exp_touch = 1'b0;
        if (diff <= -t4) exp_cal = 1'b1;
        check_state();
    endtask

    initial begin
        void'($urandom(32'h25fe2cd8));
        {kick, slow, was_status, exp_touch, exp_cal} = 5'h00;
        exp_thr = 6'h0a;
        repeat (4) @(posedge clk_sys);
        acq_signal <= 12'h400 + W'($urandom % 256);
        reset_n <= 1'b1;
        #1;
        check(16'(threshold_operand), 16'h000a);
        @(posedge clk_sys);
        kick <= 1'b1;
        @(posedge clk_sys);
        kick <= 1'b0;
        settle(0, 10);
        exp_ref = acq_signal;
        check_state();
        $display("power-up calibration test done");
        cmd({2'h2, 6'(8 + $urandom % 56)}, 0, 0);
        t4 = int'(exp_thr) * 4;
        offs = '{t4 - 1, t4, t4 - t4 / 8, t4 - t4 / 8 - 1, t4, t4};
        for (int i = 0; i < 6; i++) cmd(8'h00, offs[i], i == 5);
        $display("threshold and touch test done");
        // Codes kept clear of the threshold prefix so none of them is decoded
        foreach (offs[i]) cmd(8'h02 + 8'(i * 13), t4, 0);
        cmd(8'hc0, t4, 0);
        $display("unknown command test done");
        cmd(8'h04, t4, 0);
        cmd(8'h04, -t4, 0);
        cmd(8'h00, -t4, 0);
        $display("status test done");
        // Recalibrate after the error, with a rule-breaking frame inside it
        slow = 1'b1;
        @(posedge clk_sys);
        acq_signal <= exp_ref + 12'h014;
        base = n_acq;
        host.xfer(touch_slider_pkg::CMD_CALIBRATE, rx);
        check(16'(rx), 16'h0000);
        for (tries = 0; tries < 100 && data_ready_line !== 1'b0; tries++) @(posedge clk_sys);
        if (tries == 100) begin
            n_mismatch++;
            finish_test();
        end
        host.xfer(8'hbf, rx);
        settle(base, 10);
        slow = 1'b0;
        exp_ref = acq_signal;
        {exp_touch, exp_cal, was_status} = 3'h0;
        check_state();
        $display("calibrate test done");
        foreach (offs[i]) offs[i] = (i == 0) ? 1 : (i == 1) ? t4 : -1;
        for (int p = 0; p < 3; p++) begin
            cmd(8'h00, offs[p], 0);
            repeat (10) cmd(8'h03, offs[p], 0);
        end
        $display("drift test done");
        // Select held high: free-running bursts drift every six
        @(posedge clk_sys);
        acq_signal <= exp_ref - 12'h001;
        base = n_acq;
        settle(base, 6);
        exp_ref = exp_ref - 12'h001;
        check_state();
        $display("free-run test done");
        finish_test();
    end
endmodule
